// ---- include/ecp_defs.svh ----
// Timing constants of the parallel port handshake engine
`ifndef ECP_DEFS_SVH
`define ECP_DEFS_SVH

`define ECP_CLK_NS       40
`define ECP_CYC_MIN(t)   ((((t) + `ECP_CLK_NS) - 1) / `ECP_CLK_NS)

`define ECP_SETUP_NS     600
`define ECP_STROBE_NS    600
`define ECP_HOLD_NS      450
`define ECP_GAP_NS       680
`define ECP_ACT_NS       80
`define ECP_FILT_NS      75

`define ECP_SETUP_CYC    `ECP_CYC_MIN(`ECP_SETUP_NS)
`define ECP_STROBE_CYC   `ECP_CYC_MIN(`ECP_STROBE_NS)
`define ECP_HOLD_CYC     `ECP_CYC_MIN(`ECP_HOLD_NS)
`define ECP_GAP_CYC      `ECP_CYC_MIN(`ECP_GAP_NS)
`define ECP_ACT_CYC      `ECP_CYC_MIN(`ECP_ACT_NS)
`define ECP_FILT_CYC     `ECP_CYC_MIN(`ECP_FILT_NS)

`define ECP_BUSY_RST     1'b0
`define ECP_PCLK_RST     1'b1

`endif

// ---- include/ecp_pkg.sv ----
// Types shared by the parallel port handshake engine
package ecp_pkg;

    typedef enum logic [1:0] {
        MODE_COMPAT_FIFO,
        MODE_ECP_FWD,
        MODE_ECP_REV
    } port_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_FWD_BUSY,
        ST_FWD_DONE,
        ST_RIDLE,
        ST_RACK
    } eng_state_t;

endpackage

// ---- logic/data_fifo.sv ----
// Byte FIFO with registered read data
`timescale 1ns/1ps
module data_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  empty_out
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("data_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [AW:0]      count_q, count_d;
    logic             full_q, full_d, ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             wr, ld;

    always_comb begin
        wr       = in_valid_in && !full_q;
        ld       = (count_q != '0) && (!ov_q || out_ready_in);
        wr_ptr_d = wr ? wr_ptr_q + AW'(1) : wr_ptr_q;
        rd_ptr_d = ld ? rd_ptr_q + AW'(1) : rd_ptr_q;
        count_d  = count_q + (AW+1)'(wr) - (AW+1)'(ld);
        full_d   = (count_d == (AW+1)'(DEPTH));
        od_d     = ld ? mem[rd_ptr_q] : od_q;
        ov_d     = ld ? 1'b1 : (out_ready_in ? 1'b0 : ov_q);
    end

    always_ff @(posedge core_clk_in) begin
        if (wr) begin
            mem[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            full_q   <= 1'b0;
            ov_q     <= 1'b0;
            od_q     <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
            full_q   <= full_d;
            ov_q     <= ov_d;
            od_q     <= od_d;
        end
    end

    assign in_ready_out  = !full_q;
    assign out_valid_out = ov_q;
    assign out_data_out  = od_q;
    assign empty_out     = !ov_q && (count_q == '0);

endmodule

// ---- logic/ecp_host_engine.sv ----
// Host handshake engine of the extended-capabilities parallel port
`timescale 1ns/1ps
`include "ecp_defs.svh"
module ecp_host_engine #(
    parameter int DATA_W     = 8,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic               core_clk_in,
    input  wire logic               sys_rst_in,
    input  wire ecp_pkg::port_mode_t mode_in,
    input  wire logic [DATA_W-1:0]  tx_data_in,
    input  wire logic               tx_valid_in,
    output logic                    tx_ready_out,
    output logic      [DATA_W-1:0]  rx_data_out,
    output logic                    rx_valid_out,
    input  wire logic               rx_ready_in,
    input  wire logic               tc_in,
    input  wire logic               busy_in,
    input  wire logic               periph_clock_line_in,
    input  wire logic [DATA_W-1:0]  port_data_in,
    output logic      [DATA_W-1:0]  port_data_out,
    output logic                    port_data_oe_out,
    output logic                    host_strobe_out,
    output logic                    host_strobe_oe_out,
    output logic                    host_ack_line_out,
    output logic                    host_ack_line_oe_out
);
    import ecp_pkg::*;

    if (DATA_W != 8 || FIFO_DEPTH < 2) begin : g_chk
        $error("ecp_host_engine: port is one byte wide and needs a FIFO");
    end

    localparam logic [4:0] SETUP_LAST  = 5'(`ECP_SETUP_CYC - 1);
    localparam logic [4:0] STROBE_LAST = 5'(`ECP_STROBE_CYC - 1);
    localparam logic [4:0] HOLD_LAST   = 5'(`ECP_HOLD_CYC - 1);
    localparam logic [4:0] GAP_MIN     = 5'(`ECP_GAP_CYC);
    localparam logic [4:0] ACT_MIN     = 5'(`ECP_ACT_CYC);
    localparam logic [4:0] ACT_LAST    = 5'(`ECP_ACT_CYC - 1);

    logic              busy_f, pclk_f;
    logic [DATA_W-1:0] pd_meta_q, pd_sync_q;
    eng_state_t        state_q, state_d;
    port_mode_t        mode_q, mode_d;
    logic [4:0]        cnt_q, cnt_d, gap_q, gap_d;
    logic [4:0]        low_run_q, low_run_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic              strobe_q, strobe_d, ack_q, ack_d;
    logic              drv_pp_q, drv_pp_d, data_oe_q, data_oe_d;
    logic              st_pin_q, st_pin_d, st_oe_q, st_oe_d;
    logic              ak_pin_q, ak_pin_d, ak_oe_q, ak_oe_d;
    logic              pop, cap, rev;
    logic              f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_empty;
    logic [DATA_W-1:0] f_in_data, f_out_data;

    in_filter #(.STABLE(`ECP_FILT_CYC), .RST_VAL(`ECP_BUSY_RST)) u_busy_filt (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .raw_in      (busy_in),
        .level_out   (busy_f)
    );

    in_filter #(.STABLE(`ECP_FILT_CYC), .RST_VAL(`ECP_PCLK_RST)) u_pclk_filt (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .raw_in      (periph_clock_line_in),
        .level_out   (pclk_f)
    );

    // One FIFO serves whichever direction is active
    assign rev         = (mode_q == MODE_ECP_REV);
    assign f_in_valid  = rev ? cap : tx_valid_in;
    assign f_in_data   = rev ? pd_sync_q : tx_data_in;
    assign f_out_ready = rev ? rx_ready_in : pop;

    data_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_in   (core_clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (f_in_valid),
        .in_ready_out  (f_in_ready),
        .in_data_in    (f_in_data),
        .out_valid_out (f_out_valid),
        .out_ready_in  (f_out_ready),
        .out_data_out  (f_out_data),
        .empty_out     (f_empty)
    );

    // Handshake sequencer
    always_comb begin
        state_d = state_q;
        mode_d  = mode_q;
        cnt_d   = cnt_q;
        data_d  = data_q;
        strobe_d = strobe_q;
        ack_d   = ack_q;
        pop     = 1'b0;
        cap     = 1'b0;
        gap_d   = busy_f ? 5'h0 : ((gap_q == 5'h1f) ? gap_q : gap_q + 5'h1);
        // Length of the current strobe low run, saturating
        low_run_d = strobe_q ? 5'h0 : ((low_run_q == 5'h1f) ? low_run_q : low_run_q + 5'h1);
        case (state_q)
            ST_IDLE: begin
                strobe_d = 1'b1;
                ack_d    = 1'b1;
                cnt_d    = 5'h0;
                if (rev) begin
                    ack_d   = 1'b0;
                    state_d = ST_RIDLE;
                end else if (f_out_valid && mode_q == MODE_COMPAT_FIFO) begin
                    pop     = 1'b1;
                    data_d  = f_out_data;
                    state_d = ST_SETUP;
                end else if (f_out_valid && !busy_f && gap_q >= ACT_MIN) begin
                    pop      = 1'b1;
                    data_d   = f_out_data;
                    strobe_d = 1'b0;
                    state_d  = ST_FWD_BUSY;
                end else if (f_empty && strobe_q) begin
                    mode_d = mode_in;
                end
            end
            ST_SETUP: begin
                if (cnt_q >= SETUP_LAST && gap_q >= GAP_MIN) begin
                    strobe_d = 1'b0;
                    cnt_d    = 5'h0;
                    state_d  = ST_STROBE;
                end else if (cnt_q < SETUP_LAST) begin
                    cnt_d = cnt_q + 5'h1;
                end
            end
            ST_STROBE: begin
                if (cnt_q >= STROBE_LAST) begin
                    strobe_d = 1'b1;
                    cnt_d    = 5'h0;
                    state_d  = ST_HOLD;
                end else begin
                    cnt_d = cnt_q + 5'h1;
                end
            end
            ST_HOLD: begin
                if (cnt_q >= HOLD_LAST && !busy_f) begin
                    state_d = ST_IDLE;
                end else if (cnt_q < HOLD_LAST) begin
                    cnt_d = cnt_q + 5'h1;
                end
            end
            ST_FWD_BUSY: begin
                if (!busy_f) begin
                    cnt_d = 5'h0;
                end else if (cnt_q >= ACT_LAST) begin
                    strobe_d = 1'b1;
                    state_d  = ST_FWD_DONE;
                end else begin
                    cnt_d = cnt_q + 5'h1;
                end
            end
            ST_FWD_DONE: begin
                if (!busy_f) begin
                    state_d = ST_IDLE;
                end
            end
            ST_RIDLE: begin
                ack_d = 1'b0;
                if (!rev) begin
                    state_d = ST_IDLE;
                end else if (!pclk_f && f_in_ready && !tc_in) begin
                    if (cnt_q >= ACT_LAST) begin
                        ack_d   = 1'b1;
                        cap     = 1'b1;
                        cnt_d   = 5'h0;
                        state_d = ST_RACK;
                    end else begin
                        cnt_d = cnt_q + 5'h1;
                    end
                end else begin
                    cnt_d = 5'h0;
                    if (pclk_f && f_empty) begin
                        mode_d = mode_in;
                    end
                end
            end
            ST_RACK: begin
                if (!pclk_f) begin
                    cnt_d = 5'h0;
                end else if (cnt_q >= ACT_LAST) begin
                    ack_d   = 1'b0;
                    cnt_d   = 5'h0;
                    state_d = ST_RIDLE;
                end else begin
                    cnt_d = cnt_q + 5'h1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Pin drivers: type changes only while both control lines rest high
    always_comb begin
        drv_pp_d  = (strobe_q && ack_q) ? (mode_q != MODE_COMPAT_FIFO) : drv_pp_q;
        data_oe_d = !rev;
        st_oe_d   = drv_pp_d || !strobe_d;
        st_pin_d  = drv_pp_d && strobe_d;
        ak_oe_d   = drv_pp_d || !ack_d;
        ak_pin_d  = drv_pp_d && ack_d;
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pd_meta_q <= '0;
            pd_sync_q <= '0;
            state_q   <= ST_IDLE;
            mode_q    <= MODE_COMPAT_FIFO;
            cnt_q     <= 5'h0;
            gap_q     <= 5'h0;
            low_run_q <= 5'h0;
            data_q    <= '0;
            strobe_q  <= 1'b1;
            ack_q     <= 1'b1;
            drv_pp_q  <= 1'b0;
            data_oe_q <= 1'b0;
            st_pin_q  <= 1'b0;
            st_oe_q   <= 1'b0;
            ak_pin_q  <= 1'b0;
            ak_oe_q   <= 1'b0;
        end else begin
            pd_meta_q <= port_data_in;
            pd_sync_q <= pd_meta_q;
            state_q   <= state_d;
            mode_q    <= mode_d;
            cnt_q     <= cnt_d;
            gap_q     <= gap_d;
            low_run_q <= low_run_d;
            data_q    <= data_d;
            strobe_q  <= strobe_d;
            ack_q     <= ack_d;
            drv_pp_q  <= drv_pp_d;
            data_oe_q <= data_oe_d;
            st_pin_q  <= st_pin_d;
            st_oe_q   <= st_oe_d;
            ak_pin_q  <= ak_pin_d;
            ak_oe_q   <= ak_oe_d;
        end
    end

    assign tx_ready_out         = f_in_ready && !rev;
    assign rx_valid_out         = f_out_valid && rev;
    assign rx_data_out          = f_out_data;
    assign port_data_out        = data_q;
    assign port_data_oe_out     = data_oe_q;
    assign host_strobe_out      = st_pin_q;
    assign host_strobe_oe_out   = st_oe_q;
    assign host_ack_line_out    = ak_pin_q;
    assign host_ack_line_oe_out = ak_oe_q;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_rev_idle_ack: assert property (state_q == ST_RIDLE |-> !ack_q)
        else $error("acknowledge not low in reverse idle");
    a_ack_rise_min: assert property ($rose(ack_q) && rev |-> $past(!pclk_f, 1) && $past(!pclk_f, 2))
        else $error("acknowledge rose too soon after peripheral clock");
    a_ack_rise_max: assert property (
        (state_q == ST_RIDLE && rev && !pclk_f && f_in_ready && !tc_in)[*2] |=> ack_q)
        else $error("acknowledge late on peripheral clock");
    a_ack_stall: assert property ($rose(ack_q) && rev |-> $past(f_in_ready && !tc_in))
        else $error("acknowledge raised while reception stalled");
    a_ack_fall: assert property ((state_q == ST_RACK && pclk_f)[*2] |=> !ack_q)
        else $error("acknowledge did not fall after peripheral clock rose");
    a_strobe_width: assert property (
        $rose(strobe_q) && mode_q == MODE_COMPAT_FIFO |-> low_run_q >= 5'd15)
        else $error("compatibility strobe too short");
    a_strobe_setup: assert property (
        $fell(strobe_q) && mode_q == MODE_COMPAT_FIFO |-> data_q == $past(data_q, 15))
        else $error("data not stable before strobe");
    a_busy_gap: assert property (
        $fell(strobe_q) && mode_q == MODE_COMPAT_FIFO |-> $past(gap_q) >= 5'd17)
        else $error("strobe too soon after busy released");
    a_data_hold: assert property (
        $rose(strobe_q) && mode_q == MODE_COMPAT_FIFO |-> $stable(data_q)[*8] ##1 $stable(data_q)[*4])
        else $error("data not held after strobe");
    a_fwd_strobe: assert property (
        (state_q == ST_IDLE && mode_q == MODE_ECP_FWD && f_out_valid && !busy_f)[*3] |=> !strobe_q)
        else $error("forward strobe late after busy low");
    a_fwd_release: assert property (
        (state_q == ST_FWD_BUSY && !strobe_q && busy_f)[*2] |=> strobe_q)
        else $error("forward strobe not released after busy");
    a_drv_switch: assert property ($changed(drv_pp_q) |-> $past(strobe_q && ack_q))
        else $error("driver type changed while a line was low");

endmodule

// ---- logic/in_filter.sv ----
// Pin synchroniser with stability filter
`timescale 1ns/1ps
module in_filter #(
    parameter int         STABLE  = 2,
    parameter logic       RST_VAL = 1'b0
) (
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic raw_in,
    output logic      level_out
);

    if (STABLE < 1 || STABLE > 7) begin : g_chk
        $error("in_filter: STABLE out of range");
    end

    logic       meta_q, sync_q, last_q, level_q;
    logic       level_d;
    logic [2:0] cnt_q, cnt_d;
    localparam logic [2:0] CNT_LAST = 3'(STABLE - 1);

    // Counter restarts on every change of the synchronised input
    always_comb begin
        level_d = level_q;
        cnt_d   = 3'h0;
        if (sync_q == last_q && sync_q != level_q) begin
            if (cnt_q == CNT_LAST) begin
                level_d = sync_q;
            end else begin
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            meta_q  <= RST_VAL;
            sync_q  <= RST_VAL;
            last_q  <= RST_VAL;
            level_q <= RST_VAL;
            cnt_q   <= 3'h0;
        end else begin
            meta_q  <= raw_in;
            sync_q  <= meta_q;
            last_q  <= sync_q;
            level_q <= level_d;
            cnt_q   <= cnt_d;
        end
    end

    assign level_out = level_q;

    a_filter_stable: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        $changed(level_q) |-> ($past(sync_q, 1) == level_q) && ($past(sync_q, 2) == level_q)
                              && ($past(sync_q, 3) == level_q))
        else $error("filtered level changed before input was stable");

endmodule

// ---- sim/ecp_parallel_handshake_tb.sv ----
// Self-checking bench of the parallel port host handshake engine
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin mismatches++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module ecp_parallel_handshake_tb;
    import ecp_pkg::*;
    logic       core_clk_in = 1'b0;
    logic       sys_rst_in  = 1'b1;
    port_mode_t mode_in     = MODE_COMPAT_FIFO;
    logic [7:0] tx_data_in  = 8'h00;
    logic       tx_valid_in = 1'b0;
    logic       rx_ready_in = 1'b0;
    logic       tc_in       = 1'b0;
    logic       hold_busy   = 1'b0;
    logic       glitch      = 1'b0;
    logic [2:0] lag         = 3'h0;
    logic       rx_en       = 1'b0;
    logic       stall       = 1'b0;
    logic       s_q, b_q, a_q, c_q, in_x;
    logic       tx_ready_out, rx_valid_out, port_data_oe_out, pm_busy, pclk, busy_in;
    logic       host_strobe_out, host_strobe_oe_out, host_ack_line_out, host_ack_line_oe_out;
    logic [7:0] rx_data_out, port_data_out, port_data_in, pm_data, tmp, last;
    logic       strobe_w, ack_w;
    logic [7:0] fwd_q[$];
    logic [7:0] rev_q[$];
    int         mismatches, n_tests, cyc, acc, c_lo, c_bf, c_br, c_cf, c_cr;

    assign strobe_w     = host_strobe_oe_out ? host_strobe_out : 1'b1;
    assign ack_w        = host_ack_line_oe_out ? host_ack_line_out : 1'b1;
    assign busy_in      = pm_busy | hold_busy;
    assign port_data_in = port_data_oe_out ? port_data_out : pm_data;

    always #20 core_clk_in = ~core_clk_in;

    ecp_host_engine dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .mode_in(mode_in),
        .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
        .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in),
        .tc_in(tc_in), .busy_in(busy_in), .periph_clock_line_in(pclk),
        .port_data_in(port_data_in), .port_data_out(port_data_out),
        .port_data_oe_out(port_data_oe_out), .host_strobe_out(host_strobe_out),
        .host_strobe_oe_out(host_strobe_oe_out), .host_ack_line_out(host_ack_line_out),
        .host_ack_line_oe_out(host_ack_line_oe_out));

    ecp_periph_model pm (.core_clk_in(core_clk_in), .strobe_in(strobe_w), .ack_in(ack_w),
        .glitch_in(glitch), .lag_in(lag), .busy_out(pm_busy), .pclk_out(pclk),
        .data_out(pm_data));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk_in);
            tx_valid_in = 1'b1;
            tx_data_in = 8'($urandom);
            @(posedge core_clk_in);
            while (tx_ready_out !== 1'b1) @(posedge core_clk_in);
            fwd_q.push_back(tx_data_in);
        end
        @(negedge core_clk_in);
        tx_valid_in = 1'b0;
    endtask

    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            tmp = 8'($urandom);
            pm.tx_q.push_back(tmp);
            rev_q.push_back(tmp);
        end
    endtask

    task automatic settle();
        while (fwd_q.size() + rev_q.size() + pm.tx_q.size() != 0) @(posedge core_clk_in);
        repeat (60) @(negedge core_clk_in);
    endtask

    always @(negedge core_clk_in) rx_ready_in <= rx_en & 1'($urandom_range(1, 0));

    // Wire monitor: timing and data on the cable
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
        if (!sys_rst_in) begin
            if (!strobe_w && s_q) begin
                tmp = fwd_q.pop_front();
                `CHK("fwd data", tmp, port_data_in)
                if (mode_in == MODE_COMPAT_FIFO) `CHK("busy gap", 1'b1, c_bf >= 17)
            end
            if (strobe_w && !s_q && mode_in == MODE_COMPAT_FIFO) `CHK("width", 1'b1, c_lo >= 15)
            if (strobe_w && !s_q && mode_in == MODE_ECP_FWD) `CHK("release", 1'b1, c_br inside {[3:10]})
            if (pm_busy && !b_q) `CHK("strobe at busy", 1'b0, strobe_w)
            if (ack_w && !a_q && mode_in == MODE_ECP_REV) begin
                in_x = 1'b1;
                if (!stall) `CHK("ack rise", 1'b1, c_cf inside {[3:10]})
            end
            if (!ack_w && a_q && in_x) begin
                in_x = 1'b0;
                `CHK("ack fall", 1'b1, c_cr inside {[3:10]})
            end
            if (rx_valid_out === 1'b1 && rx_ready_in) begin
                tmp = rev_q.pop_front();
                `CHK("rx data", tmp, rx_data_out)
            end
        end
        c_lo = strobe_w ? 0 : c_lo + 1;
        c_bf = busy_in ? 0 : c_bf + 1;
        c_br = (pm_busy && !b_q) ? 0 : c_br + 1;
        c_cf = (!pclk && c_q) ? 0 : c_cf + 1;
        c_cr = (pclk && !c_q) ? 0 : c_cr + 1;
        s_q = strobe_w;
        b_q = pm_busy;
        a_q = ack_w;
        c_q = pclk;
    end

    initial begin
        in_x = 1'b0;
        void'($urandom(32'hd19bbe71));
        repeat (12) @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        `CHK("tx ready", 1'b1, tx_ready_out)
        `CHK("rx valid", 1'b0, rx_valid_out)
        // Compatibility: fill against held busy, then drain
        hold_busy = 1'b1;
        acc = 0;
        for (int i = 0; i < 14; i++) begin
            @(negedge core_clk_in);
            tx_valid_in = 1'b1;
            tx_data_in = 8'($urandom);
            @(posedge core_clk_in);
            if (tx_ready_out === 1'b1) begin
                acc++;
                fwd_q.push_back(tx_data_in);
                last = tx_data_in;
            end
        end
        @(negedge core_clk_in);
        tx_valid_in = 1'b0;
        `CHK("accepted", 1'b1, acc inside {[9:10]})
        `CHK("strobe held", 1'b1, strobe_w)
        lag = 3'($urandom_range(4, 0));
        hold_busy = 1'b0;
        settle();
        `CHK("data held", last, port_data_in)
        `CHK("open drain", 1'b0, host_strobe_oe_out)
        // Extended forward, then a filtered spike on busy
        mode_in = MODE_ECP_FWD;
        push(12);
        settle();
        glitch = 1'b1;
        push(1);
        settle();
        glitch = 1'b0;
        `CHK("push-pull", 1'b1, host_strobe_oe_out)
        `CHK("ack fwd", 1'b1, ack_w)
        // Reverse traffic, stall on count, stall on full buffer
        mode_in = MODE_ECP_REV;
        repeat (10) @(negedge core_clk_in);
        `CHK("rev data oe", 1'b0, port_data_oe_out)
        `CHK("rev idle ack", 1'b0, ack_w)
        rx_en = 1'b1;
        lag = 3'($urandom_range(4, 0));
        send(12);
        settle();
        stall = 1'b1;
        tc_in = 1'b1;
        send(1);
        repeat (40) @(negedge core_clk_in);
        `CHK("tc stall", 1'b0, ack_w)
        tc_in = 1'b0;
        settle();
        rx_en = 1'b0;
        send(14);
        repeat (400) @(negedge core_clk_in);
        `CHK("full stall", 1'b0, ack_w)
        `CHK("bytes waiting", 1'b1, pm.tx_q.size() > 0)
        rx_en = 1'b1;
        settle();
        complete_run();
    end
endmodule

// ---- sim/ecp_periph_model.sv ----
// Peripheral model on the far side of the parallel port cable
`timescale 1ns/1ps
module ecp_periph_model (
    input  wire logic       core_clk_in,
    input  wire logic       strobe_in,
    input  wire logic       ack_in,
    input  wire logic       glitch_in,
    input  wire logic [2:0] lag_in,
    output logic            busy_out,
    output logic            pclk_out,
    output logic      [7:0] data_out
);
    logic [7:0] tx_q[$];
    initial begin
        busy_out = 1'b0;
        pclk_out = 1'b1;
        data_out = 8'h00;
    end
    // Forward: answer each strobe, optionally after a short spike
    always begin
        @(negedge strobe_in);
        if (glitch_in) begin
            busy_out <= 1'b1;
            repeat (2) @(posedge core_clk_in);
            busy_out <= 1'b0;
            repeat (8) @(posedge core_clk_in);
        end
        repeat (lag_in + 1) @(posedge core_clk_in);
        busy_out <= 1'b1;
        wait (strobe_in === 1'b1);
        repeat (lag_in + 1) @(posedge core_clk_in);
        busy_out <= 1'b0;
    end
    // Reverse: send queued bytes
    always begin
        while (tx_q.size() == 0) @(posedge core_clk_in);
        wait (ack_in === 1'b0);
        @(posedge core_clk_in);
        data_out <= tx_q.pop_front();
        repeat (lag_in + 1) @(posedge core_clk_in);
        pclk_out <= 1'b0;
        wait (ack_in === 1'b1);
        @(posedge core_clk_in);
        pclk_out <= 1'b1;
        wait (ack_in === 1'b0);
        @(posedge core_clk_in);
        data_out <= ~data_out;
    end
endmodule
